/* File: sar_ctl_pkg.sv */
// Purpose: shared constants and types for the converter sequence controller
// Assumes: AHB-Lite word registers, 125 MHz hclk
// Notes:   offsets are byte addresses
package sar_ctl_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0]  ctrl_one_offset     = 8'h00;
    localparam logic [7:0]  ctrl_two_offset     = 8'h04;
    localparam logic [7:0]  ctrl_three_offset   = 8'h08;
    localparam logic [7:0]  pins_offset         = 8'h0c;
    localparam logic [7:0]  buffer_base_offset  = 8'h40;

    localparam logic [15:0] ctrl_one_reset      = 16'h0000;
    localparam logic [15:0] ctrl_two_reset      = 16'h0000;
    localparam logic [15:0] ctrl_three_reset    = 16'h0000;

    // writable masks, reserved and unimplemented bits dropped
    localparam logic [15:0] ctrl_one_wmask      = 16'ha3e6;
    localparam logic [15:0] ctrl_two_wmask      = 16'he43f;
    localparam logic [15:0] ctrl_three_wmask    = 16'h9fff;

    // ****************************************
    // field positions
    // ****************************************
    localparam int on_bit        = 15;
    localparam int idle_bit      = 13;
    localparam int form_lo       = 8;
    localparam int trig_lo       = 5;
    localparam int auto_bit      = 2;
    localparam int sample_enable_bit      = 1;
    localparam int done_bit      = 0;
    localparam int vref_lo       = 13;
    localparam int scan_bit      = 10;
    localparam int fill_bit      = 7;
    localparam int rate_lo       = 2;
    localparam int buffer_mode_bit      = 1;
    localparam int alternate_sample_bit      = 0;
    localparam int rc_bit        = 15;
    localparam int samc_lo       = 8;

    // ****************************************
    // codes and counts
    // ****************************************
    localparam logic [2:0] trig_manual  = 3'h0;
    localparam logic [2:0] trig_ext     = 3'h1;
    localparam logic [2:0] trig_t3      = 3'h2;
    localparam logic [2:0] trig_t5      = 3'h4;
    localparam logic [2:0] trig_ctu     = 3'h6;
    localparam logic [2:0] trig_auto    = 3'h7;
    localparam logic [7:0] div_max      = 8'h3f;
    localparam logic [4:0] convert_tads = 5'h0c;

    typedef enum logic [3:0] {
        st_off     = 4'b0001,
        st_hold    = 4'b0010,
        st_sample  = 4'b0100,
        st_convert = 4'b1000
    } seq_state_type;

    typedef struct packed {
        logic       ext_edge;
        logic       third_timer;
        logic       fifth_timer;
        logic       charge_time_unit;
    } trigger_in_type;

    typedef struct packed {
        logic       sample;
        logic       start;
        logic       use_mux_b;
        logic [3:0] scan_index;
        logic       scan;
        logic [2:0] reference_config;
    } analog_ctl_type;

endpackage : sar_ctl_pkg

/* File: sar_adc_sequence_control.sv */
// Purpose: sample/convert sequencer, result buffer and registers of a 10-bit SAR converter
// Assumes: AHB-Lite slave, zero wait states, core result valid when core_done pulses
// Notes:   conversion clock from divided hclk or rc_tick strobe
//
// Contract
// (R1) format 10-bit result into 16-bit word per two-bit format field
// (R2) trigger 111 ends sampling by internal sample counter; 101, 011 reserved
// (R3) triggers: clear sample-enable, ext pin edge, third_timer, fifth_timer, charge-time event
// (R4) auto-start restarts sampling after each conversion and sets sample-enable
// (R5) sample-enable reads one while acquiring, zero while holding
// (R6) read-only done bit set on completion, cleared while converting
// (R7) buffer contents need not survive clearing converter-on
// (R8) software reads results before clearing converter-on
// (R9) idle-stop halts converter while processor idles
// (R10) reference field selects internal or external references, 1xx internal
// (R11) scan enable steps MUX A positive input through selected inputs
// (R12) fill-status shows which half is filling in split mode
// (R13) interrupt after every (N+1)th sequence
// (R14) buffer-mode one gives two eight-word halves, else sixteen words
// (R15) alternate-sample uses A first then alternates B and A
// (R16) clock-source one selects RC clock, zero the system clock
// (R17) auto-sample time counts 0..31 conversion clock periods
// (R18) divider period is field+1 cycles, codes above 63 reserved
// (R19) software configures everything before setting converter-on
// (R20) fixed conversion length, then done and write to next buffer word
// (R21) reserved bits read zero and writes to them do nothing
//
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module sar_adc_sequence_control
    import sar_ctl_pkg::*;
#(
    parameter int result_width = 10,
    parameter int buffer_depth = 16
) (
    // bus
    input  wire logic                         hclk,
    input  wire logic                         hresetn,
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic      [31:0]                  hrdata,
    output logic                              hreadyout,
    output logic                              hresp,
    // system
    input  wire logic                         cpu_idle,
    input  wire logic                         rc_tick,
    input  wire sar_ctl_pkg::trigger_in_type  trigger_in,
    input  wire logic [15:0]                  scan_select,
    // converter core
    input  wire logic                         core_done,
    input  wire logic [result_width-1:0]      core_result,
    output sar_ctl_pkg::analog_ctl_type       analog_ctl,
    output logic                              converter_irq_flag
);
    import sar_ctl_pkg::*;

    // ****************************************
    // registers and bus
    // ****************************************
    logic [15:0]        ctrl_one;
    logic [15:0]        ctrl_two;
    logic [15:0]        ctrl_three;
    logic [15:0]        buffer_mem [buffer_depth];
    logic               wr_pend;
    logic [7:0]         wr_addr;
    seq_state_type      state;
    logic [7:0]         div_count;
    logic [4:0]         tad_count;
    logic [3:0]         seq_count;
    logic [3:0]         wr_ptr;
    logic               fill_half;
    logic               mux_b;
    logic [3:0]         scan_pos;
    logic               done_flag;

    wire        addr_phase  = hsel && hready && htrans[1];
    wire        wr_one      = wr_pend && wr_addr == ctrl_one_offset;
    wire        wr_two      = wr_pend && wr_addr == ctrl_two_offset;
    wire        wr_three    = wr_pend && wr_addr == ctrl_three_offset;
    wire        is_buf      = haddr[7:6] == buffer_base_offset[7:6];
    wire [15:0] wdata       = hwdata[15:0];

    wire        conv_on     = ctrl_one[on_bit];
    wire        halted      = ctrl_one[idle_bit] && cpu_idle;  // R9
    wire        running     = conv_on && !halted;
    wire [1:0]  form        = ctrl_one[form_lo +: 2];
    wire [2:0]  trig        = ctrl_one[trig_lo +: 3];
    wire        auto_start  = ctrl_one[auto_bit];
    wire        split       = ctrl_two[buffer_mode_bit];
    wire [3:0]  rate        = ctrl_two[rate_lo +: 4];
    wire [4:0]  samc        = ctrl_three[samc_lo +: 5];
    wire [7:0]  divider     = ctrl_three[7:0] > div_max ? div_max : ctrl_three[7:0];  // R18

    // ****************************************
    // conversion clock tick
    // ****************************************
    wire        sys_tick    = div_count == divider;  // R18
    wire        tad_tick    = ctrl_three[rc_bit] ? rc_tick : sys_tick;  // R16

    // ****************************************
    // sequence decode
    // ****************************************
    wire        sw_clear    = wr_one && !wdata[sample_enable_bit];
    wire        sw_set      = wr_one && wdata[sample_enable_bit];
    wire        trig_hit    = (trig == trig_manual && sw_clear)
                           || (trig == trig_ext && trigger_in.ext_edge)
                           || (trig == trig_t3 && trigger_in.third_timer)
                           || (trig == trig_t5 && trigger_in.fifth_timer)
                           || (trig == trig_ctu && trigger_in.charge_time_unit)
                           || (trig == trig_auto && tad_tick && tad_count >= samc);  // R2 R3 R17
    wire        convert_end = state == st_convert && core_done
                           && tad_count >= convert_tads;  // R20
    wire [3:0]  half_last   = split ? 4'h7 : 4'hf;
    wire [3:0]  wrap_at     = rate < half_last ? rate : half_last;
    wire [3:0]  slot        = split ? {fill_half, wr_ptr[2:0]} : wr_ptr;  // R14
    wire        seq_last    = seq_count == rate;  // R13
    wire [15:0] res_word;
    wire [15:0] next_ctrl_one;

    // format: integer, signed integer, fraction, signed fraction
    wire [result_width-1:0] res_signed = {~core_result[result_width-1], core_result[result_width-2:0]};
    assign res_word = form == 2'h0 ? {{(16-result_width){1'b0}}, core_result}  // R1
                    : form == 2'h1 ? {{(16-result_width){res_signed[result_width-1]}}, res_signed}
                    : form == 2'h2 ? {core_result, {(16-result_width){1'b0}}}
                    : {res_signed, {(16-result_width){1'b0}}};

    // scan: next selected input after current
    logic [3:0] scan_next;
    always_comb begin
        scan_next = scan_pos;
        for (int i = 16; i >= 1; i--) begin
            if (scan_select[4'(scan_pos + 4'(i))]) begin
                scan_next = 4'(scan_pos + 4'(i));
            end
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    seq_state_type next_state;
    always_comb begin
        next_state = state;
        case (state)
            st_off:     next_state = running ? (auto_start ? st_sample : st_hold) : st_off;
            st_hold:    next_state = !running ? st_off : (sw_set ? st_sample : st_hold);  // R4
            st_sample:  next_state = !running ? st_off : (trig_hit ? st_convert : st_sample);
            st_convert: next_state = !running ? st_off
                                   : convert_end ? (auto_start ? st_sample : st_hold) : st_convert;  // R4
            default:    next_state = st_off;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= st_off;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_count <= 8'h00;
            tad_count <= 5'h00;
        end else begin
            div_count <= (sys_tick || !running) ? 8'h00 : 8'(div_count + 8'h01);
            if (next_state != state) begin
                tad_count <= 5'h00;
            end else if (tad_tick && tad_count != 5'h1f) begin
                tad_count <= 5'(tad_count + 5'h01);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_flag <= 1'b0;
        end else if (state == st_sample && next_state == st_convert) begin
            done_flag <= 1'b0;  // R6
        end else if (convert_end) begin
            done_flag <= 1'b1;  // R6
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr       <= 4'h0;
            seq_count    <= 4'h0;
            fill_half    <= 1'b0;
            mux_b        <= 1'b0;
            scan_pos     <= 4'h0;
        end else if (!conv_on) begin
            wr_ptr       <= 4'h0;
            seq_count    <= 4'h0;
            fill_half    <= 1'b0;
            mux_b        <= 1'b0;
            scan_pos     <= 4'h0;
        end else if (convert_end) begin
            wr_ptr    <= wr_ptr == wrap_at ? 4'h0 : 4'(wr_ptr + 4'h1);  // R20
            seq_count <= seq_last ? 4'h0 : 4'(seq_count + 4'h1);
            if (split && seq_last) begin
                fill_half <= ~fill_half;  // R12
            end
            mux_b <= ctrl_two[alternate_sample_bit] ? ~mux_b : 1'b0;  // R15
            // step only after a MUX A sample, so every A sample sees a new input
            if (ctrl_two[scan_bit] && !mux_b) begin
                scan_pos <= scan_next;  // R11
            end
        end
    end

    always_ff @(posedge hclk) begin
        if (convert_end) begin
            buffer_mem[slot] <= res_word;  // R20
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            converter_irq_flag <= 1'b0;
        end else begin
            converter_irq_flag <= convert_end && seq_last;  // R13
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    // sample bit shows the state; hardware auto-set wins over a clearing write
    assign next_ctrl_one = wr_one ? (wdata & ctrl_one_wmask) : ctrl_one;  // R21

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_one   <= ctrl_one_reset;
            ctrl_two   <= ctrl_two_reset;
            ctrl_three <= ctrl_three_reset;
        end else begin
            ctrl_one <= {next_ctrl_one[15:2], next_state == st_sample, done_flag};  // R5 R4
            if (wr_two) begin
                ctrl_two <= wdata & ctrl_two_wmask;  // R21
            end
            if (wr_three) begin
                ctrl_three <= wdata & ctrl_three_wmask;  // R21
            end
        end
    end

    // ****************************************
    // bus slave
    // ****************************************
    wire [15:0] ctrl_two_rd = {ctrl_two[15:8], split && fill_half, ctrl_two[6:0]};  // R12
    wire [15:0] rd_value    = is_buf && conv_on ? buffer_mem[haddr[5:2]]  // R7
                            : haddr[7:0] == ctrl_one_offset   ? ctrl_one
                            : haddr[7:0] == ctrl_two_offset   ? ctrl_two_rd
                            : haddr[7:0] == ctrl_three_offset ? ctrl_three
                            : 16'h0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend   <= addr_phase && hwrite;
            wr_addr   <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addr_phase && !hwrite) begin
                hrdata <= {16'h0000, rd_value};
            end
        end
    end

    // ****************************************
    // analog side
    // ****************************************
    wire [2:0] vref = ctrl_two[vref_lo + 2] ? 3'h0 : ctrl_two[vref_lo +: 3];  // R10

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            analog_ctl <= '0;
        end else begin
            analog_ctl.sample           <= next_state == st_sample;
            analog_ctl.start            <= state == st_sample && next_state == st_convert;
            analog_ctl.use_mux_b        <= mux_b;  // R15
            analog_ctl.scan_index       <= scan_pos;
            analog_ctl.scan             <= ctrl_two[scan_bit];
            analog_ctl.reference_config <= vref;
        end
    end

endmodule : sar_adc_sequence_control

/* File: sar_core_model.sv */
// Purpose: converter core stand-in for the sequence controller
// Assumes: start pulse begins one conversion
// Notes:   result toggles outside the valid cycle
`timescale 1ns/100ps
module sar_core_model (
    // clock
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // control
    input  wire logic       start,
    input  wire logic [7:0] delay,
    input  wire logic [9:0] value,
    // result
    output logic            done,
    output logic [9:0]      result
);
    logic [7:0] cnt;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt    <= 8'h00;
            done   <= 1'b0;
            result <= 10'h000;
        end else begin
            cnt    <= start ? delay : (cnt != 8'h00) ? cnt - 8'h01 : cnt;
            done   <= (cnt == 8'h01);
            result <= (cnt == 8'h01) ? value : ~result;
        end
    end
endmodule : sar_core_model

/* File: sar_adc_sequence_control_props.sv */
// Purpose: port checker for the converter sequence controller
// Assumes: single hclk domain
// Notes:   bound to every instance of the controller
`timescale 1ns/100ps
module sar_adc_sequence_control_props
    import sar_ctl_pkg::*;
(
    // clock and reset
    input wire logic                        hclk,
    input wire logic                        hresetn,
    // observed outputs and the core_done input
    input wire logic [31:0]                 hrdata,
    input wire logic                        core_done,
    input wire sar_ctl_pkg::analog_ctl_type analog_ctl,
    input wire logic                        converter_irq_flag
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_HRDATA_HIGH_ZERO: assert property (hrdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    AST_REF_LOW_CODES: assert property (!analog_ctl.reference_config[2])
        else $error("reference code above three reached the core");
    AST_CONVERT_LENGTH: assert property (analog_ctl.start |=> !analog_ctl.start [*8])
        else $error("conversion restarted too early");
    AST_HOLD_AT_START: assert property (analog_ctl.start |-> !analog_ctl.sample)
        else $error("sampling while conversion starts");
    AST_SAMPLE_BEFORE_START: assert property ($rose(analog_ctl.start) |-> $past(analog_ctl.sample))
        else $error("conversion started without sampling");
    AST_IRQ_PULSE: assert property (converter_irq_flag |=> !converter_irq_flag)
        else $error("interrupt longer than one cycle");
    AST_IRQ_AFTER_DONE: assert property (converter_irq_flag |-> $past(core_done) || $past(core_done, 2))
        else $error("interrupt without core result");
    AST_NO_START_IN_SAMPLE: assert property ($rose(analog_ctl.sample) |-> !analog_ctl.start)
        else $error("start pulse as sampling begins");
endmodule : sar_adc_sequence_control_props
bind sar_adc_sequence_control sar_adc_sequence_control_props u_sar_adc_sequence_control_props (
    .hclk(hclk), .hresetn(hresetn), .hrdata(hrdata), .core_done(core_done),
    .analog_ctl(analog_ctl), .converter_irq_flag(converter_irq_flag));

/* File: sar_adc_sequence_control_bench.sv */
// Purpose: register level tests of the converter sequence controller
// Assumes: zero wait state slave, divider zero so one tad is one hclk, except in the rc clock and divider clamp tests
// Notes:   core stand-in answers after a set delay
`timescale 1ns/100ps
module sar_adc_sequence_control_bench;
    import sar_ctl_pkg::*;
    logic hclk, hresetn, hwrite, hreadyout, hresp, cpu_idle, core_done, converter_irq_flag;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [15:0] rd;
    logic [9:0]  core_result;
    logic [7:0]  delay;
    logic        rc_tick;
    logic [15:0] scan_sel;
    trigger_in_type trigger_in;
    analog_ctl_type analog_ctl;
    int miscompares, checks_done, cycles, starts_n, s0;
    logic [7:0]  offs [3] = '{ctrl_one_offset, ctrl_two_offset, ctrl_three_offset};
    logic [15:0] wm [3]   = '{ctrl_one_wmask, ctrl_two_wmask, ctrl_three_wmask};
    logic [15:0] fmt [4]  = '{16'h0125, 16'hff25, 16'h4940, 16'hc940};
    logic [3:0]  tbit [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
    logic [2:0]  tcode [4] = '{trig_ext, trig_t3, trig_t5, trig_ctu};
    sar_adc_sequence_control u_sar_adc_sequence_control (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cpu_idle(cpu_idle), .rc_tick(rc_tick),
        .trigger_in(trigger_in), .scan_select(scan_sel), .core_done(core_done), .core_result(core_result),
        .analog_ctl(analog_ctl), .converter_irq_flag(converter_irq_flag));
    sar_core_model u_sar_core_model (.hclk(hclk), .hresetn(hresetn), .start(analog_ctl.start),
        .delay(delay), .value(10'h125), .done(core_done), .result(core_result));
    // ****************************************
    // clock, timeout and tasks
    // ****************************************
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (analog_ctl.start) starts_n <= starts_n + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            test_done();
        end
    end
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] wd);
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {24'h000000, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= {16'h0000, wd};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata[15:0];
    endtask : bus
    task automatic wait_irq();
        int n;
        n = 0;
        while (converter_irq_flag !== 1'b1 && n < 400) begin
            @(posedge hclk);
            n = n + 1;
        end
        chk("interrupt", 16'h0001, {15'h0, n < 400});
    endtask : wait_irq
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    // ****************************************
    // tests
    // ****************************************
    initial begin
        {hresetn, hwrite, cpu_idle, haddr, hwdata, htrans, trigger_in, rc_tick, scan_sel} = '0;
        {miscompares, checks_done, cycles, starts_n} = '0;
        delay = 8'h0e;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 3; i++) begin
            bus(0, offs[i], 16'h0000);
            chk("reset value", 16'h0000, rd);
            bus(1, offs[i], ~wm[i]);
            bus(0, offs[i], 16'h0000);
            chk("reserved bits", 16'h0000, rd);
        end
        bus(0, 8'h20, 16'h0000);
        chk("unmapped", 16'h0000, rd);
        chk("response", 16'h0000, {15'h0, hresp});
        for (int v = 0; v < 8; v++) begin
            bus(1, ctrl_two_offset, 16'(v << 13));
            repeat (2) @(posedge hclk);
            chk("reference", v[2] ? 16'h0000 : 16'(v), {13'h0, analog_ctl.reference_config});
        end
        bus(1, ctrl_two_offset, 16'h0000);
        for (int f = 0; f < 4; f++) begin
            bus(1, ctrl_one_offset, 16'h8000 | 16'(f << 8));
            bus(1, ctrl_one_offset, 16'h8002 | 16'(f << 8));
            bus(0, ctrl_one_offset, 16'h0000);
            chk("sample bit", 16'h0001, {15'h0, rd[1]});
            bus(1, ctrl_one_offset, 16'h8000 | 16'(f << 8));
            wait_irq();
            bus(0, ctrl_one_offset, 16'h0000);
            chk("done bit", 16'h0001, {14'h0, rd[1:0]});
            bus(0, buffer_base_offset, 16'h0000);
            chk("formatted result", fmt[f], rd);
        end
        delay = 8'h28;
        for (int t = 0; t < 4; t++) begin
            bus(1, ctrl_one_offset, 16'h8000 | 16'(tcode[t] << 5));
            bus(1, ctrl_one_offset, 16'h8002 | 16'(tcode[t] << 5));
            repeat (20) @(posedge hclk);
            chk("waits for trigger", 16'h0001, {15'h0, analog_ctl.sample});
            trigger_in <= tbit[t];
            @(posedge hclk);
            trigger_in <= 4'h0;
            wait_irq();
        end
        delay = 8'h0e;
        bus(1, ctrl_three_offset, 16'h0200);
        bus(1, ctrl_two_offset, 16'h000c);
        bus(1, ctrl_one_offset, 16'h80e6);
        wait_irq();
        s0 = starts_n;
        @(posedge hclk);
        wait_irq();
        chk("sequences per interrupt", 16'h0004, 16'(starts_n - s0));
        repeat (2) @(posedge hclk);
        chk("auto restart", 16'h0001, {15'h0, analog_ctl.sample});
        bus(0, buffer_base_offset + 8'h0c, 16'h0000);
        chk("fourth word", 16'h0125, rd);
        bus(1, ctrl_one_offset, 16'ha0e4);
        cpu_idle <= 1'b1;
        repeat (40) @(posedge hclk);
        s0 = starts_n;
        repeat (100) @(posedge hclk);
        chk("idle stop", 16'(s0), 16'(starts_n));
        cpu_idle <= 1'b0;
        wait_irq();
        bus(1, ctrl_one_offset, 16'h0000);
        bus(0, buffer_base_offset, 16'h0000);
        chk("buffer after off", 16'h0000, rd);
        // split, alternate, scan inputs one and two, interrupt every sequence
        scan_sel <= 16'h0006;
        bus(1, ctrl_two_offset, 16'h0403);
        bus(1, ctrl_one_offset, 16'h80e4);
        for (int k = 1; k < 5; k++) begin
            wait_irq();
            repeat (2) @(posedge hclk);
            chk("mux b", 16'(k % 2), {15'h0, analog_ctl.use_mux_b});
            chk("scan index", 16'((k + 1) / 2), {12'h0, analog_ctl.scan_index});
            bus(0, ctrl_two_offset, 16'h0000);
            chk("fill status", 16'(k % 2), {15'h0, rd[7]});
        end
        bus(0, buffer_base_offset + 8'h20, 16'h0000);
        chk("upper half word", 16'h0125, rd);
        bus(1, ctrl_one_offset, 16'h0000);
        bus(1, ctrl_three_offset, 16'h8200);
        bus(1, ctrl_one_offset, 16'h80e4);
        repeat (30) @(posedge hclk);
        chk("rc clock idle", 16'h0001, {15'h0, analog_ctl.sample});
        rc_tick <= 1'b1;
        wait_irq();
        // divider code above the limit runs as 64 cycles per period
        bus(1, ctrl_one_offset, 16'h0000);
        bus(1, ctrl_three_offset, 16'h00ff);
        bus(1, ctrl_one_offset, 16'h80e4);
        s0 = starts_n;
        repeat (40) @(posedge hclk);
        chk("divider early", 16'(s0), 16'(starts_n));
        repeat (30) @(posedge hclk);
        chk("divider clamp", 16'(s0 + 1), 16'(starts_n));
        test_done();
    end
endmodule : sar_adc_sequence_control_bench
